// File: include/sts_cfg.svh
// constants of the supply and thermal supervisor: offsets, fields, resets, timing
// assumes a 200 MHz system clock and a 32-bit classic Wishbone register port
//
// Overview of operation
// - oscillator source pin picks crystal or external clock
// - stand-by after power-up gives 4 MHz host clock
// - normal: rate pin low 8 MHz, high 16 MHz
// - host clock enable bit stops the clock pin
// - normal to stand-by keeps fast clock unless oscillator fault
// - trigger enable bit: marker one bit time early
// - marker falls on transmission end or collision
// - idle-bus frames and replies start in the same cycle as marker
// - supply below 14 V drops power warning at once
// - bus below 20 V for 2 ms drops warning
// - supply below 12 V holds host reset low
// - host interface active only in stand-by and normal
// - rails stay up unless they caused stand-by
// - thermal warning drops power warning; host reads status
// - shutdown: reset state, sticky flag, supplies stopped
// - shutdown gone: start-up, then stand-by, reset released
// - normal needs no warning, good voltages; releases warning
// - thermal warning status bit follows live condition
// - sticky shutdown clears on read once condition gone
// - four voltage supervisor outputs readable as status bits
// - normal needs oscillator, no thermal, all four bits
`ifndef STS_CFG_SVH
`define STS_CFG_SVH

// clock and timing
`define STS_CLK_MHZ        200
`define STS_BUS_LOW_US     2000
`define STS_BUS_LOW_CYC    (`STS_BUS_LOW_US * `STS_CLK_MHZ)
`define STS_OSC_WAIT_US    2000
`define STS_OSC_WAIT_CYC   (`STS_OSC_WAIT_US * `STS_CLK_MHZ)
`define STS_BIT_TIME_NS    104167
`define STS_BIT_TIME_CYC   ((`STS_BIT_TIME_NS * `STS_CLK_MHZ + 999) / 1000)
`define STS_HCLK_SLOW_MHZ  4
`define STS_HCLK_MID_MHZ   8
`define STS_HCLK_FAST_MHZ  16
`define STS_HALF_SLOW      (`STS_CLK_MHZ / (2 * `STS_HCLK_SLOW_MHZ))
`define STS_HALF_MID       (`STS_CLK_MHZ / (2 * `STS_HCLK_MID_MHZ))
`define STS_HALF_FAST      (`STS_CLK_MHZ / (2 * `STS_HCLK_FAST_MHZ))

// register byte offsets
`define STS_ADDR_CTRL      4'h0
`define STS_ADDR_STAT      4'h4
`define STS_ADDR_THERM     4'h8

// control register fields and reset value
`define STS_CTRL_HCLK_EN   0
`define STS_CTRL_TX_MARKER_OUT_EN   3
`define STS_CTRL_RESET     32'h0000_0001

// status register fields
`define STS_STAT_BUS       0
`define STS_STAT_FILT      1
`define STS_STAT_ADJ       2
`define STS_STAT_AUX       3
`define STS_STAT_TW        4
`define STS_STAT_OSC       5
`define STS_STAT_STATE_LO  8

// thermal register field
`define STS_THERM_TSD      0

`endif

// File: include/sts_pkg.sv
// types of the supply and thermal supervisor
// assumes sts_cfg.svh is included by the design files for the numbers
package sts_pkg;

  // supervisor states, one-hot
  typedef enum logic [3:0] {
    STS_RESET   = 4'b0001,
    STS_STARTUP = 4'b0010,
    STS_STANDBY = 4'b0100,
    STS_NORMAL  = 4'b1000
  } sts_state_t;

  // host clock rate choice
  typedef enum logic [1:0] {
    STS_RATE_SLOW = 2'h0,
    STS_RATE_MID  = 2'h1,
    STS_RATE_FAST = 2'h2
  } sts_rate_t;

endpackage : sts_pkg

// File: rtl/sts_persist.sv
// persistence filter: flag rises once a condition held for a set number of cycles
// assumes the condition input is synchronous to clk_i
`timescale 1ns/1ps
`default_nettype none
module sts_persist #(
  parameter int unsigned COUNT = 400000,
  parameter int unsigned CW    = 20
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // condition and result
  input  wire logic cond_i,
  output logic      held_o
);
  import sts_pkg::*;

  initial begin
    if (COUNT < 1 || COUNT >= (64'd1 << CW)) $error("sts_persist: COUNT does not fit CW");
  end

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          held;
  } sts_pst_t;

  sts_pst_t s_q, s_d;

  // count while the condition stands, restart the moment it breaks
  always_comb begin
    s_d = s_q;
    if (!cond_i) begin
      s_d.cnt  = '0;
      s_d.held = 1'b0;
    end else if (s_q.cnt == CW'(COUNT - 1)) begin
      s_d.held = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + CW'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) s_q <= '0;
    else       s_q <= s_d;
  end

  assign held_o = s_q.held;

endmodule : sts_persist
`default_nettype wire

// File: rtl/sts_clkgen.sv
// host clock generator: toggles the clock pin at a chosen half period
// assumes rate and enable come from registers of the same clock
`timescale 1ns/1ps
`default_nettype none
`include "sts_cfg.svh"
module sts_clkgen (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // control
  input  wire logic              run_i,
  input  wire sts_pkg::sts_rate_t rate_i,
  // pin
  output logic                   clk_o,
  output logic                   oe_n_o
);
  import sts_pkg::*;

  typedef struct packed {
    logic [7:0] cnt;
    logic       clk;
    logic       oe_n;
  } sts_cg_t;

  sts_cg_t s_q, s_d;
  logic [7:0] half;

  // 200 MHz does not divide to 8 or 16 MHz exactly; half periods round down
  always_comb begin
    case (rate_i)
      STS_RATE_FAST: half = 8'(`STS_HALF_FAST);
      STS_RATE_MID:  half = 8'(`STS_HALF_MID);
      default:       half = 8'(`STS_HALF_SLOW);
    endcase
  end

  // divider gives a one-cycle toggle enable; stopped pin is released low
  always_comb begin
    s_d      = s_q;
    s_d.oe_n = !run_i;
    if (!run_i) begin
      s_d.cnt = '0;
      s_d.clk = 1'b0;
    end else if (s_q.cnt >= half - 8'h01) begin
      s_d.cnt = '0;
      s_d.clk = !s_q.clk;
    end else begin
      s_d.cnt = s_q.cnt + 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) s_q <= '{cnt: 8'h00, clk: 1'b0, oe_n: 1'b1};
    else       s_q <= s_d;
  end

  assign clk_o  = s_q.clk;
  assign oe_n_o = s_q.oe_n;

endmodule : sts_clkgen
`default_nettype wire

// File: rtl/sts_top.sv
// supply and thermal supervisor: state sequencing, host reset and warning,
// host clock selection, transmit marker and Wishbone status registers
// assumes all comparator and sensor inputs are synchronous to clk_i
`timescale 1ns/1ps
`default_nettype none
`include "sts_cfg.svh"
module sts_top #(
  parameter int unsigned BUS_LOW_CYC  = `STS_BUS_LOW_CYC,
  parameter int unsigned OSC_WAIT_CYC = `STS_OSC_WAIT_CYC,
  parameter int unsigned BIT_CYC      = `STS_BIT_TIME_CYC
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // supervisor inputs
  input  wire logic        filt_run_ok_i,
  input  wire logic        filt_ok_i,
  input  wire logic        filt_warn_ok_i,
  input  wire logic        filt_hold_ok_i,
  input  wire logic        bus_voltage_ok_i,
  input  wire logic        fixed_rail_ok_i,
  input  wire logic        trim_done_i,
  input  wire logic        adjustable_rail_ok_i,
  input  wire logic        aux_high_rail_ok_i,
  input  wire logic        thermal_warning_i,
  input  wire logic        thermal_shutdown_i,
  // oscillator
  input  wire logic        osc_source_sel_i,
  input  wire logic        xtal_ok_i,
  input  wire logic        ext_clk_ok_i,
  output logic             osc_en_o,
  // host clock
  input  wire logic        host_clock_rate_sel_i,
  output logic             host_clock_out_o,
  output logic             host_clock_out_oe_n_o,
  // open-drain host pins, oe low while pulling low
  output logic             host_reset_n_o,
  output logic             host_reset_oe_n_o,
  output logic             power_warning_n_o,
  output logic             power_warning_oe_n_o,
  // supplies and interfaces
  output logic             fixed_rail_en_o,
  output logic             rails_en_o,
  output logic             host_if_active_o,
  output logic             bus_comm_en_o,
  // transmit marker
  input  wire logic        tx_req_i,
  input  wire logic        tx_sched_i,
  input  wire logic        tx_done_i,
  input  wire logic        tx_collision_i,
  output logic             tx_start_o,
  output logic             tx_marker_out_o
);
  import sts_pkg::*;

  initial begin
    if (BIT_CYC < 1 || BIT_CYC >= (1 << 24)) $error("sts_top: BIT_CYC out of range");
  end

  typedef struct packed {
    sts_state_t  state;
    logic        from_normal;
    logic        osc_fault;
    logic        rail_fault;
    logic        hclk_fast;
    logic        hclk_en;
    logic        tx_marker_out_en;
    logic        tsd_flag;
    logic        osc_en;
    logic        tx_busy;
    logic        lead_act;
    logic [23:0] lead_cnt;
    logic        tx_start;
    logic        marker;
    logic        ack;
    logic [31:0] rdat;
    logic        reset_n;
    logic        warn_n;
    logic        fixed_en;
    logic        rails_en;
    logic        if_active;
    logic        comm_en;
  } sts_top_t;

  sts_top_t s_q, s_d;

  logic       bus_low;
  logic       osc_wait_done;
  logic       osc_started;
  logic       normal_ok;
  logic       wb_req;
  logic       hclk_run;
  sts_rate_t  hclk_rate;
  logic [3:0] st_bits;

  // bus below 20 V must hold before the bus bit drops
  sts_persist #(.COUNT(BUS_LOW_CYC), .CW(20)) u_bus_low (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .cond_i (!bus_voltage_ok_i),
    .held_o (bus_low)
  );

  // oscillator starts a while after stand-by is reached
  sts_persist #(.COUNT(OSC_WAIT_CYC), .CW(20)) u_osc_wait (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .cond_i (s_q.state == STS_STANDBY || s_q.state == STS_NORMAL),
    .held_o (osc_wait_done)
  );

  // selected source decides which ready indication counts
  assign osc_started = s_q.osc_en && (osc_source_sel_i ? ext_clk_ok_i : xtal_ok_i);

  // all conditions for the normal state
  assign normal_ok = osc_started && !thermal_warning_i && !thermal_shutdown_i
                     && !bus_low && filt_ok_i && adjustable_rail_ok_i
                     && aux_high_rail_ok_i && filt_warn_ok_i;

  assign wb_req  = wb_cyc_i && wb_stb_i && !s_q.ack;
  assign st_bits = s_q.state;

  // clock runs in stand-by and normal unless software turned it off
  assign hclk_run  = s_q.hclk_en && (s_q.state == STS_STANDBY || s_q.state == STS_NORMAL);
  assign hclk_rate = !s_q.hclk_fast ? STS_RATE_SLOW
                   : (host_clock_rate_sel_i ? STS_RATE_FAST : STS_RATE_MID);

  sts_clkgen u_clkgen (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .run_i  (hclk_run),
    .rate_i (hclk_rate),
    .clk_o  (host_clock_out_o),
    .oe_n_o (host_clock_out_oe_n_o)
  );

  // state sequencing, registers and marker in one next-state process
  always_comb begin
    s_d          = s_q;
    s_d.ack      = 1'b0;
    s_d.tx_start = 1'b0;

    // sequencing; shutdown or a dead supply always wins
    if (thermal_shutdown_i || !filt_run_ok_i) begin
      s_d.state = STS_RESET;
    end else begin
      case (s_q.state)
        STS_RESET: s_d.state = STS_STARTUP;
        STS_STARTUP: begin
          if (fixed_rail_ok_i && trim_done_i) begin
            s_d.state       = STS_STANDBY;
            s_d.from_normal = 1'b0;
          end
        end
        STS_STANDBY: begin
          if (!fixed_rail_ok_i) s_d.state = STS_RESET;
          else if (normal_ok) begin
            s_d.state     = STS_NORMAL;
            s_d.hclk_fast = 1'b1;
            s_d.osc_fault = 1'b0;
            s_d.rail_fault = 1'b0;
          end
        end
        STS_NORMAL: begin
          if (!fixed_rail_ok_i) s_d.state = STS_RESET;
          else if (!normal_ok) begin
            s_d.state       = STS_STANDBY;
            s_d.from_normal = 1'b1;
            s_d.osc_fault   = !osc_started;
            s_d.hclk_fast   = osc_started;
            s_d.rail_fault  = !adjustable_rail_ok_i || !aux_high_rail_ok_i;
          end
        end
        default: s_d.state = STS_RESET;
      endcase
    end
    if (s_d.state == STS_RESET || s_d.state == STS_STARTUP) begin
      s_d.hclk_fast   = 1'b0;
      s_d.from_normal = 1'b0;
      s_d.osc_fault   = 1'b0;
      s_d.rail_fault  = 1'b0;
    end

    // oscillator held off until the start delay in stand-by
    s_d.osc_en = (s_d.state == STS_STANDBY || s_d.state == STS_NORMAL)
                 && (osc_wait_done || s_q.osc_en);

    // pins and enables follow the next state
    s_d.reset_n   = (s_d.state == STS_STANDBY || s_d.state == STS_NORMAL)
                    && filt_hold_ok_i;
    s_d.warn_n    = (s_d.state == STS_NORMAL) && filt_warn_ok_i
                    && !bus_low && !thermal_warning_i;
    s_d.fixed_en  = (s_d.state != STS_RESET);
    s_d.rails_en  = (s_d.state == STS_NORMAL)
                    || (s_d.state == STS_STANDBY && filt_ok_i
                        && !(s_d.from_normal && s_d.rail_fault));
    s_d.if_active = (s_d.state == STS_STANDBY || s_d.state == STS_NORMAL);
    s_d.comm_en   = (s_d.state == STS_NORMAL);

    // transmit marker; a new request is taken only once the previous has finished
    if (s_q.marker && (tx_done_i || tx_collision_i)) s_d.marker = 1'b0;
    if (s_q.tx_busy && (tx_done_i || tx_collision_i)) begin
      s_d.tx_busy  = 1'b0;
      s_d.lead_act = 1'b0;
    end else if (s_q.lead_act) begin
      if (s_q.lead_cnt == 24'h000000) begin
        s_d.lead_act = 1'b0;
        s_d.tx_start = 1'b1;
      end else begin
        s_d.lead_cnt = s_q.lead_cnt - 24'h000001;
      end
    end else if (tx_req_i && !s_q.tx_busy && s_q.comm_en) begin
      s_d.tx_busy = 1'b1;
      s_d.marker  = s_q.tx_marker_out_en;
      if (tx_sched_i) begin
        s_d.lead_act = 1'b1;
        s_d.lead_cnt = 24'(BIT_CYC - 1);
      end else begin
        s_d.tx_start = 1'b1;
      end
    end
    if (!s_d.comm_en) begin
      s_d.tx_busy  = 1'b0;
      s_d.lead_act = 1'b0;
      s_d.marker   = 1'b0;
    end

    // sticky shutdown flag; setting beats a clearing read
    if (wb_req && !wb_we_i && wb_adr_i == `STS_ADDR_THERM && !thermal_shutdown_i) begin
      s_d.tsd_flag = 1'b0;
    end
    if (thermal_shutdown_i) s_d.tsd_flag = 1'b1;

    // wishbone: answer one cycle after the request, unmapped reads zero
    if (wb_req) begin
      s_d.ack  = 1'b1;
      s_d.rdat = 32'h0000_0000;
      if (wb_we_i && wb_adr_i == `STS_ADDR_CTRL && wb_sel_i[0]) begin
        s_d.hclk_en = wb_dat_i[`STS_CTRL_HCLK_EN];
        s_d.tx_marker_out_en = wb_dat_i[`STS_CTRL_TX_MARKER_OUT_EN];
      end
      if (!wb_we_i) begin
        case (wb_adr_i)
          `STS_ADDR_CTRL: begin
            s_d.rdat[`STS_CTRL_HCLK_EN] = s_q.hclk_en;
            s_d.rdat[`STS_CTRL_TX_MARKER_OUT_EN] = s_q.tx_marker_out_en;
          end
          `STS_ADDR_STAT: begin
            s_d.rdat[`STS_STAT_BUS]  = !bus_low;
            s_d.rdat[`STS_STAT_FILT] = filt_ok_i;
            s_d.rdat[`STS_STAT_ADJ]  = adjustable_rail_ok_i;
            s_d.rdat[`STS_STAT_AUX]  = aux_high_rail_ok_i;
            s_d.rdat[`STS_STAT_TW]   = thermal_warning_i;
            s_d.rdat[`STS_STAT_OSC]  = osc_started;
            s_d.rdat[`STS_STAT_STATE_LO +: 4] = st_bits;
          end
          `STS_ADDR_THERM: s_d.rdat[`STS_THERM_TSD] = s_q.tsd_flag;
          default: s_d.rdat = 32'h0000_0000;
        endcase
      end
    end
  end

  // one register for all state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q          <= '0;
      s_q.state    <= STS_RESET;
      s_q.hclk_en  <= 1'(`STS_CTRL_RESET >> `STS_CTRL_HCLK_EN);
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register
  assign wb_dat_o             = s_q.rdat;
  assign wb_ack_o             = s_q.ack;
  assign osc_en_o             = s_q.osc_en;
  assign host_reset_n_o       = s_q.reset_n;
  assign host_reset_oe_n_o    = s_q.reset_n;
  assign power_warning_n_o    = s_q.warn_n;
  assign power_warning_oe_n_o = s_q.warn_n;
  assign fixed_rail_en_o      = s_q.fixed_en;
  assign rails_en_o           = s_q.rails_en;
  assign host_if_active_o     = s_q.if_active;
  assign bus_comm_en_o        = s_q.comm_en;
  assign tx_start_o           = s_q.tx_start;
  assign tx_marker_out_o      = s_q.marker;

  // checks on the sequencing and pins
  early_reset_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_q.state == STS_RESET || s_q.state == STS_STARTUP) |-> !host_reset_n_o)
    else $error("host reset released before stand-by");
  warn_state_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s_q.state != STS_NORMAL |-> !power_warning_n_o)
    else $error("power warning high outside normal");
  supply14_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !filt_warn_ok_i |=> !power_warning_n_o)
    else $error("power warning late on low supply");
  supply12_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !filt_hold_ok_i |=> !host_reset_n_o)
    else $error("host reset high on very low supply");
  thermal_warn_a: assert property (@(posedge clk_i) disable iff (rst_i)
    thermal_warning_i |=> !power_warning_n_o && s_q.state != STS_NORMAL)
    else $error("thermal warning not signalled");
  shutdown_a: assert property (@(posedge clk_i) disable iff (rst_i)
    thermal_shutdown_i |=> s_q.state == STS_RESET && s_q.tsd_flag && !fixed_rail_en_o)
    else $error("shutdown not entered");
  tsd_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
    thermal_shutdown_i && wb_req |=> s_q.tsd_flag)
    else $error("shutdown flag lost during condition");
  lead_time_a: assert property (@(posedge clk_i) disable iff (rst_i)
    tx_req_i && tx_sched_i && !s_q.tx_busy && s_q.comm_en && bus_comm_en_o
    && !(tx_done_i || tx_collision_i) |=> !tx_start_o [*8])
    else $error("scheduled start came too early");
  immediate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    tx_req_i && !tx_sched_i && !s_q.tx_busy && s_q.comm_en && s_d.comm_en |=> tx_start_o)
    else $error("unscheduled start delayed");
  marker_drop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    tx_marker_out_o && (tx_done_i || tx_collision_i) |=> !tx_marker_out_o)
    else $error("marker stayed high after end");
  normal_entry_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s_q.state == STS_STANDBY && s_d.state == STS_NORMAL |-> osc_started && !bus_low)
    else $error("normal entered without conditions");
  clock_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !s_q.hclk_en |=> host_clock_out_oe_n_o)
    else $error("host clock still driven when disabled");

  // main scenarios
  reach_normal_c: cover property (@(posedge clk_i) disable iff (rst_i)
    s_q.state == STS_STANDBY ##1 s_q.state == STS_NORMAL);
  osc_fall_c: cover property (@(posedge clk_i) disable iff (rst_i)
    s_q.state == STS_NORMAL ##1 s_q.state == STS_STANDBY && s_q.osc_fault);
  sched_tx_c: cover property (@(posedge clk_i) disable iff (rst_i)
    tx_marker_out_o && s_q.lead_act ##[1:1000] tx_start_o);

endmodule : sts_top
`default_nettype wire

// File: tb/sts_host_model.sv
// host controller model: measures the host clock and watches reset and warning
// assumes the bench resolves open-drain pins to wire levels
`timescale 1ns/1ps
`default_nettype none
module sts_host_model (
  // clock
  input  wire logic clk_i,
  // pins
  input  wire logic hclk_i,
  input  wire logic hclk_oe_n_i,
  input  wire logic rst_n_i,
  input  wire logic warn_n_i,
  // observations
  output int        half_o,
  output logic      need_read_o
);
  int   cnt_q;
  logic last_q;
  // half period in system cycles; a held host ignores its clock pin
  always @(posedge clk_i) begin
    last_q <= hclk_i;
    need_read_o <= !warn_n_i && rst_n_i; // warning must be confirmed by a read
    if (hclk_oe_n_i || !rst_n_i) begin // no traffic while held
      cnt_q <= 0;
    end else if (hclk_i !== last_q) begin
      half_o <= cnt_q + 1;
      cnt_q <= 0;
    end else begin
      cnt_q <= cnt_q + 1;
    end
  end
endmodule : sts_host_model
`default_nettype wire

// File: tb/supply_thermal_supervisor_test.sv
// bench of the supply and thermal supervisor with a host model beside it
// assumes shortened counts: bus filter 20, oscillator wait 10, bit time 12
`timescale 1ns/1ps
`default_nettype none
`include "sts_cfg.svh"
module supply_thermal_supervisor_test;
  import sts_pkg::*;
  localparam int BIT = 12;
  logic        clk_i, rst_i, cyc, stb, we, rsel, osel, xok, eok, need;
  logic        ack, hclk, hoe_n, roe_n, woe_n, bcomm, hif, rails, frail, tst, mark;
  logic        oen, rpo, wpo;
  logic [3:0]  adr, tx;
  logic [10:0] sv;
  logic [31:0] dat, rd, dat_o;
  int          half, n_mismatch, check_count, exp_st, seed, n;
  int          bl[3] = '{1, 7, 8};
  // open-drain pins with pull-up: level follows the enable
  wire rpin = roe_n;
  wire wpin = woe_n;
  sts_top #(.BUS_LOW_CYC(20), .OSC_WAIT_CYC(10), .BIT_CYC(BIT)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .filt_run_ok_i(sv[0]), .filt_ok_i(sv[1]), .filt_warn_ok_i(sv[2]),
    .filt_hold_ok_i(sv[3]), .bus_voltage_ok_i(sv[4]), .fixed_rail_ok_i(sv[5]),
    .trim_done_i(sv[6]), .adjustable_rail_ok_i(sv[7]), .aux_high_rail_ok_i(sv[8]),
    .thermal_warning_i(sv[9]), .thermal_shutdown_i(sv[10]), .osc_source_sel_i(osel),
    .xtal_ok_i(xok), .ext_clk_ok_i(eok), .osc_en_o(oen), .host_clock_rate_sel_i(rsel),
    .host_clock_out_o(hclk), .host_clock_out_oe_n_o(hoe_n), .host_reset_n_o(rpo),
    .host_reset_oe_n_o(roe_n), .power_warning_n_o(wpo), .power_warning_oe_n_o(woe_n),
    .fixed_rail_en_o(frail), .rails_en_o(rails), .host_if_active_o(hif),
    .bus_comm_en_o(bcomm), .tx_req_i(tx[0]), .tx_sched_i(tx[1]), .tx_done_i(tx[2]),
    .tx_collision_i(tx[3]), .tx_start_o(tst), .tx_marker_out_o(mark));
  sts_host_model host (.clk_i(clk_i), .hclk_i(hclk), .hclk_oe_n_i(hoe_n),
    .rst_n_i(rpin), .warn_n_i(wpin), .half_o(half), .need_read_o(need));
  // 200 MHz clock
  initial begin
    clk_i = 0;
    forever #2.5 clk_i = ~clk_i;
  end
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH %s exp %0h got %0h", nm, e, s);
    end
  endtask : chk
  task automatic cy(input int c);
    repeat (c) @(posedge clk_i);
  endtask : cy
  // classic single cycle; waits for ack (watchdog bounds it), then one idle cycle
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 0;
    stb <= 0;
    @(posedge clk_i);
  endtask : wb
  // poll the state field until it agrees with the expected state, at most 60 reads
  task automatic st(input int s);
    exp_st = s;
    n = 0;
    do begin
      wb(0, `STS_ADDR_STAT, 0);
      n++;
    end while (rd[11:8] !== exp_st[3:0] && n < 60);
    chk("state", rd[11:8], exp_st);
  endtask : st
  // one request pulse, counting edges until the start pulse is seen
  task automatic txgo(input logic s);
    tx <= {2'b00, s, 1'b1};
    n = 0;
    do begin
      @(posedge clk_i);
      tx <= 0;
      n++;
    end while (tst !== 1'b1 && n < 40);
  endtask : txgo
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim
  // watchdog well beyond the several hundred cycles the tests need
  initial begin
    cy(20000);
    n_mismatch++;
    end_sim();
  end
  // main sequence
  initial begin
    {cyc, stb, we, rsel, osel, xok, eok, adr, tx, sv, dat} = '0;
    seed = 32'h6564;
    rst_i = 1;
    cy(2);
    chk("rst pin", rpin, 0);
    rst_i <= 0;
    sv <= 11'h1FF;
    wb(0, `STS_ADDR_CTRL, 0);
    chk("ctrl", rd, `STS_CTRL_RESET);
    st(4);
    chk("rst pin", rpin, 1);
    chk("rst out", rpo, 1);
    chk("warn pin", wpin, 0);
    cy(80);
    chk("half", half, `STS_HALF_SLOW);
    chk("osc en", oen, 1);
    osel <= 1;
    eok <= 1;
    st(8);
    chk("warn pin", wpin, 1);
    chk("warn out", wpo, 1);
    chk("bus comm", bcomm, 1);
    cy(80);
    chk("half", half, `STS_HALF_MID);
    rsel <= 1;
    cy(60);
    chk("half", half, `STS_HALF_FAST);
    wb(1, `STS_ADDR_CTRL, 0);
    chk("clk oe", hoe_n, 1);
    wb(1, `STS_ADDR_CTRL, 1);
    $display("test clocks done");
    // each supervised rail fault in turn: stand-by, rails off, fast clock kept
    for (int i = 0; i < 3; i++) begin
      sv[bl[i]] <= 0;
      st(4);
      chk("stat bit", rd[i+1], 0);
      chk("rails", rails, 0);
      cy(60);
      chk("half", half, `STS_HALF_FAST);
      sv[bl[i]] <= 1;
      st(8);
    end
    // a short random bus dip must not warn; a long one must
    sv[4] <= 0;
    cy(1 + ($unsigned($random(seed)) % 15));
    sv[4] <= 1;
    cy(3);
    chk("warn pin", wpin, 1);
    sv[4] <= 0;
    cy(15);
    chk("warn pin", wpin, 1);
    cy(15);
    chk("warn pin", wpin, 0);
    st(4);
    chk("bus bit", rd[0], 0);
    chk("rails", rails, 1);
    sv[4] <= 1;
    st(8);
    sv[2] <= 0;
    cy(2);
    chk("warn pin", wpin, 0);
    sv[2] <= 1;
    sv[3] <= 0;
    cy(2);
    chk("rst pin", rpin, 0);
    sv[3] <= 1;
    st(8);
    $display("test supervisors done");
    wb(1, `STS_ADDR_CTRL, 32'h0000_0009);
    txgo(1);
    chk("lead", n, BIT + 2);
    chk("marker", mark, 1);
    tx <= 4'h4;
    cy(1);
    tx <= 0;
    cy(1);
    chk("marker", mark, 0);
    txgo(0);
    chk("lead", n, 2);
    chk("marker", mark, 1);
    tx <= 4'h8;
    cy(1);
    tx <= 0;
    cy(1);
    chk("marker", mark, 0);
    $display("test marker done");
    osel <= 0;
    st(4);
    cy(80);
    chk("half", half, `STS_HALF_SLOW);
    xok <= 1;
    st(8);
    sv[9] <= 1;
    cy(3);
    chk("warn pin", wpin, 0);
    wb(0, `STS_ADDR_STAT, 0);
    chk("tw bit", rd[4], 1);
    chk("host read", need, 1);
    sv[9] <= 0;
    wb(0, `STS_ADDR_STAT, 0);
    chk("tw bit", rd[4], 0);
    st(8);
    sv[10] <= 1;
    cy(3);
    chk("rst pin", rpin, 0);
    chk("fixed rail", frail, 0);
    chk("osc en", oen, 0);
    chk("host if", hif, 0);
    wb(0, `STS_ADDR_THERM, 0);
    wb(0, `STS_ADDR_THERM, 0);
    chk("tsd", rd[0], 1);
    sv[10] <= 0;
    st(8);
    chk("host if", hif, 1);
    wb(0, `STS_ADDR_THERM, 0);
    chk("tsd", rd[0], 1);
    wb(0, `STS_ADDR_THERM, 0);
    chk("tsd", rd[0], 0);
    $display("test thermal done");
    end_sim();
  end
endmodule : supply_thermal_supervisor_test
`default_nettype wire
